/* pkg/smpa_pkg.sv */
// package: constants for the state machine pin arbiter and shared flags
package smpa_pkg;
  // machine, pin and flag counts
  localparam int SMPA_NUM_SM = 4;
  localparam int SMPA_NUM_GPIO = 32;
  localparam int SMPA_NUM_USER_GPIO = 30;
  localparam int SMPA_NUM_FLAGS = 8;
  localparam int SMPA_NUM_IRQ_FLAGS = 4;
  localparam int SMPA_IMEM_DEPTH = 32;
  localparam int SMPA_INSTR_W = 16;
  // register byte offsets
  localparam logic [7:0] SMPA_OFF_PIN_CFG0 = 8'h00;
  localparam logic [7:0] SMPA_OFF_FLAG = 8'h10;
  localparam logic [7:0] SMPA_OFF_FLAG_SET = 8'h14;
  localparam logic [7:0] SMPA_OFF_IRQ0_MASK = 8'h18;
  localparam logic [7:0] SMPA_OFF_IRQ1_MASK = 8'h1C;
  localparam logic [7:0] SMPA_OFF_GPIO_LVL = 8'h20;
  localparam logic [7:0] SMPA_OFF_GPIO_DIR = 8'h24;
  localparam logic [7:0] SMPA_OFF_GPIO_IN = 8'h28;
  localparam logic [7:0] SMPA_OFF_IMEM = 8'h80;
  // pin_range_config field positions
  localparam int SMPA_F_OUT_BASE = 0;
  localparam int SMPA_F_OUT_CNT = 5;
  localparam int SMPA_F_SET_BASE = 11;
  localparam int SMPA_F_SET_CNT = 16;
  localparam int SMPA_F_SIDE_BASE = 19;
  localparam int SMPA_F_SIDE_CNT = 24;
  localparam int SMPA_F_IN_BASE = 27;
  // values after reset
  localparam logic [31:0] SMPA_RST_PIN_CFG = 32'h0000_0000;
  localparam logic [31:0] SMPA_RST_GPIO = 32'h0000_0000;
  localparam logic [7:0] SMPA_RST_FLAGS = 8'h00;
  localparam logic [3:0] SMPA_RST_MASK = 4'h0;
  localparam logic [15:0] SMPA_RST_INSTR = 16'h0000;
endpackage : smpa_pkg

/* design/smpa_range_map.sv */
// range mapper: spreads a machine's data word over a base/count pin range
`timescale 1ns/10ps
`default_nettype none
module smpa_range_map
  import smpa_pkg::*;
(
  // request
  input wire logic en_i,
  input wire logic [4:0] base_i,
  input wire logic [5:0] count_i,
  input wire logic [31:0] data_i,
  // per pin result
  output logic [31:0] mask_o,
  output logic [31:0] val_o
);
  logic [31:0] low_mask;
  logic [63:0] mask_dbl;
  logic [63:0] val_dbl;
  logic [31:0] user_mask;

  // contiguous range, wrapping past the top pin; only user pins are reachable
  always_comb begin
    low_mask = (count_i >= 6'd32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << count_i) - 32'h0000_0001);
    user_mask = (32'h0000_0001 << SMPA_NUM_USER_GPIO) - 32'h0000_0001;
    mask_dbl = {low_mask, low_mask} << base_i;
    val_dbl = {data_i, data_i} << base_i;
    mask_o = en_i ? (mask_dbl[63:32] & user_mask) : 32'h0000_0000;
    val_o = val_dbl[63:32];
  end
endmodule : smpa_range_map
`default_nettype wire

/* design/smpa_top.sv */
// top: pin output arbiter, shared flags, interrupt masks and instruction memory
`timescale 1ns/10ps
`default_nettype none
module smpa_top
  import smpa_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // instruction pin writes (out or set range)
  input wire logic [3:0] ins_wr_en_i,
  input wire logic [3:0] ins_wr_dir_i,
  input wire logic [3:0] ins_wr_set_i,
  input wire logic [3:0][31:0] ins_wr_data_i,
  // side-set pin writes
  input wire logic [3:0] side_wr_en_i,
  input wire logic [3:0] side_wr_dir_i,
  input wire logic [3:0][4:0] side_wr_data_i,
  // pin reads
  output logic [3:0][31:0] in_data_o,
  // flag operations
  input wire logic [3:0] flag_set_i,
  input wire logic [3:0] flag_clr_i,
  input wire logic [3:0][2:0] flag_idx_i,
  input wire logic [3:0] flag_wait_i,
  input wire logic [3:0] flag_wait_pol_i,
  output logic [3:0] stall_o,
  output logic [7:0] flags_o,
  // instruction fetch
  input wire logic [3:0][4:0] fetch_addr_i,
  output logic [3:0][15:0] instr_o,
  // pins and interrupts
  input wire logic [31:0] gpio_in_i,
  output logic [31:0] gpio_level_o,
  output logic [31:0] gpio_dir_o,
  output logic [1:0] irq_o
);
  // register state
  logic [3:0][31:0] pin_cfg_r, pin_cfg_nxt;
  logic [3:0] irq_line0_enable_mask_r, irq_line0_enable_mask_nxt;
  logic [3:0] irq_line1_enable_mask_r, irq_line1_enable_mask_nxt;
  logic [7:0] flag_r, flag_nxt;
  logic [31:0] lvl_r, lvl_nxt, dir_r, dir_nxt;
  logic [1:0] irq_r, irq_nxt;
  logic [3:0] stall_r, stall_nxt;
  logic [31:0] gpio_meta_r, gpio_sync_r;
  logic [3:0][31:0] in_r, in_nxt;
  logic [SMPA_IMEM_DEPTH-1:0][15:0] imem_r, imem_nxt;
  logic [3:0][15:0] instr_r, instr_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  // decoded pin ranges
  logic [3:0][31:0] ins_mask, ins_val, side_mask, side_val;
  logic [31:0] bus_flag_clr, bus_flag_set;
  logic wr_stb;

  // per machine range mapping; instruction uses out or set range
  generate
    for (genvar s = 0; s < SMPA_NUM_SM; s++) begin : g_sm
      logic [4:0] ins_base;
      logic [5:0] ins_cnt;
      assign ins_base = ins_wr_set_i[s] ? pin_cfg_r[s][SMPA_F_SET_BASE +: 5]
                                        : pin_cfg_r[s][SMPA_F_OUT_BASE +: 5];
      assign ins_cnt = ins_wr_set_i[s] ? {3'h0, pin_cfg_r[s][SMPA_F_SET_CNT +: 3]}
                                       : pin_cfg_r[s][SMPA_F_OUT_CNT +: 6];
      smpa_range_map u_ins (
        .en_i(ins_wr_en_i[s]),
        .base_i(ins_base),
        .count_i(ins_cnt),
        .data_i(ins_wr_data_i[s]),
        .mask_o(ins_mask[s]),
        .val_o(ins_val[s])
      );
      smpa_range_map u_side (
        .en_i(side_wr_en_i[s]),
        .base_i(pin_cfg_r[s][SMPA_F_SIDE_BASE +: 5]),
        .count_i({3'h0, pin_cfg_r[s][SMPA_F_SIDE_CNT +: 3]}),
        .data_i({27'h0, side_wr_data_i[s]}),
        .mask_o(side_mask[s]),
        .val_o(side_val[s])
      );
    end
  endgenerate

  // pin arbitration: later machine overrides, side-set after instruction
  always_comb begin
    lvl_nxt = lvl_r;
    dir_nxt = dir_r;
    for (int s = 0; s < SMPA_NUM_SM; s++) begin
      if (!ins_wr_dir_i[s]) begin
        lvl_nxt = (lvl_nxt & ~ins_mask[s]) | (ins_val[s] & ins_mask[s]);
      end else begin
        dir_nxt = (dir_nxt & ~ins_mask[s]) | (ins_val[s] & ins_mask[s]);
      end
      if (!side_wr_dir_i[s]) begin
        lvl_nxt = (lvl_nxt & ~side_mask[s]) | (side_val[s] & side_mask[s]);
      end else begin
        dir_nxt = (dir_nxt & ~side_mask[s]) | (side_val[s] & side_mask[s]);
      end
    end
  end

  // pin input sync and per machine in-range view
  always_comb begin
    logic [63:0] dbl;
    dbl = 64'h0;
    for (int s = 0; s < SMPA_NUM_SM; s++) begin
      dbl = {gpio_sync_r, gpio_sync_r} >> pin_cfg_r[s][SMPA_F_IN_BASE +: 5];
      in_nxt[s] = dbl[31:0];
    end
  end

  // bus write strobe and flag write decode
  always_comb begin
    wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
    bus_flag_clr = (wr_stb && wb_adr_i == SMPA_OFF_FLAG) ? wb_dat_i : 32'h0;
    bus_flag_set = (wr_stb && wb_adr_i == SMPA_OFF_FLAG_SET) ? wb_dat_i : 32'h0;
  end

  // shared flags: clears first, then sets so a set wins
  always_comb begin
    logic [7:0] set_v, clr_v;
    set_v = bus_flag_set[7:0];
    clr_v = bus_flag_clr[7:0];
    for (int s = 0; s < SMPA_NUM_SM; s++) begin
      if (flag_set_i[s]) set_v[flag_idx_i[s]] = 1'b1;
      if (flag_clr_i[s]) clr_v[flag_idx_i[s]] = 1'b1;
    end
    flag_nxt = (flag_r & ~clr_v) | set_v;
    // masks taken at their next value so a mask write and the line move together
    irq_nxt[0] = |(flag_nxt[3:0] & irq_line0_enable_mask_nxt);
    irq_nxt[1] = |(flag_nxt[3:0] & irq_line1_enable_mask_nxt);
    for (int s = 0; s < SMPA_NUM_SM; s++) begin
      stall_nxt[s] = flag_wait_i[s] && (flag_r[flag_idx_i[s]] != flag_wait_pol_i[s]);
    end
  end

  // instruction memory: one write port, four registered read ports
  always_comb begin
    imem_nxt = imem_r;
    if (wr_stb && wb_adr_i[7] && wb_sel_i[0]) imem_nxt[wb_adr_i[6:2]][7:0] = wb_dat_i[7:0];
    if (wr_stb && wb_adr_i[7] && wb_sel_i[1]) imem_nxt[wb_adr_i[6:2]][15:8] = wb_dat_i[15:8];
    for (int s = 0; s < SMPA_NUM_SM; s++) begin
      instr_nxt[s] = imem_r[fetch_addr_i[s]];
    end
  end

  // control register writes with byte lanes
  always_comb begin
    logic [31:0] be;
    be = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    pin_cfg_nxt = pin_cfg_r;
    irq_line0_enable_mask_nxt = irq_line0_enable_mask_r;
    irq_line1_enable_mask_nxt = irq_line1_enable_mask_r;
    if (wr_stb && wb_adr_i[7:4] == SMPA_OFF_PIN_CFG0[7:4]) begin
      pin_cfg_nxt[wb_adr_i[3:2]] = (pin_cfg_r[wb_adr_i[3:2]] & ~be) | (wb_dat_i & be);
    end
    if (wr_stb && wb_adr_i == SMPA_OFF_IRQ0_MASK && wb_sel_i[0]) begin
      irq_line0_enable_mask_nxt = wb_dat_i[3:0];
    end
    if (wr_stb && wb_adr_i == SMPA_OFF_IRQ1_MASK && wb_sel_i[0]) begin
      irq_line1_enable_mask_nxt = wb_dat_i[3:0];
    end
  end

  // bus answer: one cycle after request, unmapped reads give zero
  always_comb begin
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    rdat_nxt = 32'h0;
    if (wb_adr_i[7]) begin
      rdat_nxt = {16'h0, imem_r[wb_adr_i[6:2]]};
    end else if (wb_adr_i[7:4] == SMPA_OFF_PIN_CFG0[7:4]) begin
      rdat_nxt = pin_cfg_r[wb_adr_i[3:2]];
    end else begin
      case (wb_adr_i)
        SMPA_OFF_FLAG: rdat_nxt = {24'h0, flag_r};
        SMPA_OFF_IRQ0_MASK: rdat_nxt = {28'h0, irq_line0_enable_mask_r};
        SMPA_OFF_IRQ1_MASK: rdat_nxt = {28'h0, irq_line1_enable_mask_r};
        SMPA_OFF_GPIO_LVL: rdat_nxt = lvl_r;
        SMPA_OFF_GPIO_DIR: rdat_nxt = dir_r;
        SMPA_OFF_GPIO_IN: rdat_nxt = gpio_sync_r;
        default: rdat_nxt = 32'h0;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge clk_i) begin
    gpio_meta_r <= gpio_in_i;
    gpio_sync_r <= gpio_meta_r;
    if (rst_i) begin
      pin_cfg_r <= {SMPA_NUM_SM{SMPA_RST_PIN_CFG}};
      irq_line0_enable_mask_r <= SMPA_RST_MASK;
      irq_line1_enable_mask_r <= SMPA_RST_MASK;
      flag_r <= SMPA_RST_FLAGS;
      lvl_r <= SMPA_RST_GPIO;
      dir_r <= SMPA_RST_GPIO;
      irq_r <= 2'h0;
      stall_r <= 4'h0;
      in_r <= {SMPA_NUM_SM{32'h0}};
      imem_r <= {SMPA_IMEM_DEPTH{SMPA_RST_INSTR}};
      instr_r <= {SMPA_NUM_SM{SMPA_RST_INSTR}};
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      pin_cfg_r <= pin_cfg_nxt;
      irq_line0_enable_mask_r <= irq_line0_enable_mask_nxt;
      irq_line1_enable_mask_r <= irq_line1_enable_mask_nxt;
      flag_r <= flag_nxt;
      lvl_r <= lvl_nxt;
      dir_r <= dir_nxt;
      irq_r <= irq_nxt;
      stall_r <= stall_nxt;
      in_r <= in_nxt;
      imem_r <= imem_nxt;
      instr_r <= instr_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // outputs straight from registers
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign in_data_o = in_r;
  assign stall_o = stall_r;
  assign flags_o = flag_r;
  assign instr_o = instr_r;
  assign gpio_level_o = lvl_r;
  assign gpio_dir_o = dir_r;
  assign irq_o = irq_r;

  // checks
  property p_rst_pins;
    @(posedge clk_i) rst_i |=> (gpio_level_o == 32'h0 && gpio_dir_o == 32'h0);
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not cleared by reset");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      (ins_wr_en_i == 4'h0 && side_wr_en_i == 4'h0) |=> $stable(gpio_level_o) && $stable(gpio_dir_o);
  endproperty
  a_hold: assert property (p_hold) else $error("pin changed with no writer");

  property p_top_sm_wins;
    @(posedge clk_i) disable iff (rst_i)
      (ins_mask[3][0] && !ins_wr_dir_i[3] && !(side_mask[3][0] && !side_wr_dir_i[3]))
      |=> gpio_level_o[0] == $past(ins_val[3][0]);
  endproperty
  a_top_sm_wins: assert property (p_top_sm_wins) else $error("highest machine lost");

  property p_side_wins;
    @(posedge clk_i) disable iff (rst_i)
      (side_mask[3][0] && !side_wr_dir_i[3]) |=> gpio_level_o[0] == $past(side_val[3][0]);
  endproperty
  a_side_wins: assert property (p_side_wins) else $error("side-set lost to instruction");

  property p_user_pins;
    @(posedge clk_i) disable iff (rst_i) ##1 (gpio_level_o[31:30] == 2'h0 && gpio_dir_o[31:30] == 2'h0);
  endproperty
  a_user_pins: assert property (p_user_pins) else $error("non user pin driven");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i) flag_set_i[0] |=> flags_o[$past(flag_idx_i[0])];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set lost");

  property p_wait_stall;
    @(posedge clk_i) disable iff (rst_i)
      (flag_wait_i[1] && flag_r[flag_idx_i[1]] != flag_wait_pol_i[1]) |=> stall_o[1];
  endproperty
  a_wait_stall: assert property (p_wait_stall) else $error("wait did not stall");

  property p_irq_map;
    @(posedge clk_i) disable iff (rst_i)
      ##1 (irq_o[0] == |(flags_o[3:0] & irq_line0_enable_mask_r)
        && irq_o[1] == |(flags_o[3:0] & irq_line1_enable_mask_r));
  endproperty
  a_irq_map: assert property (p_irq_map) else $error("interrupt line mismatch");

  property p_fetch;
    @(posedge clk_i) disable iff (rst_i) ##1 instr_o[2] == $past(imem_r[fetch_addr_i[2]]);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch returned wrong word");

  property p_in_view;
    @(posedge clk_i) disable iff (rst_i)
      ##1 in_data_o[0][0] == $past(gpio_sync_r[pin_cfg_r[0][SMPA_F_IN_BASE +: 5]]);
  endproperty
  a_in_view: assert property (p_in_view) else $error("pin read misaligned");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
endmodule : smpa_top
`default_nettype wire

/* verification/smpa_pad_model.sv */
// pad model: pins read back their own level when driven, else the far side
`timescale 1ns/10ps
`default_nettype none
module smpa_pad_model (
  // block pin outputs
  input wire logic [31:0] level_i,
  input wire logic [31:0] dir_i,
  // far side level of undriven pins
  input wire logic [31:0] ext_i,
  // pad levels to the block
  output logic [31:0] pad_o
);
  // driven pads echo the block, undriven pads follow the far side
  assign pad_o = (dir_i & level_i) | (~dir_i & ext_i);
endmodule : smpa_pad_model
`default_nettype wire

/* verification/smpa_top_tb.sv */
// testbench: random pin traffic, flags, masks and fetch ports
`timescale 1ns/10ps
`default_nettype none
module smpa_top_tb
  import smpa_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, rd, lvl, dir, pad, ext = 32'h0, el, ed;
  logic [3:0] ie = 4'h0, idir = 4'h0, iset = 4'h0, se = 4'h0, sdir = 4'h0;
  logic [3:0] fs = 4'h0, fc = 4'h0, fw = 4'h0, fp = 4'h0, stall;
  logic [3:0][31:0] idat = '0, ind;
  logic [3:0][4:0] sdat = '0, fa = '0;
  logic [3:0][2:0] fi = '0;
  logic [3:0][15:0] ins;
  logic [7:0] flags;
  logic [1:0] irq;
  logic [31:0] cfg [4];
  int bad_count = 0;
  int comparisons = 0;
  int cyc_n = 0;
  bit chk_on = 1'b0;

  smpa_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ins_wr_en_i(ie), .ins_wr_dir_i(idir), .ins_wr_set_i(iset),
    .ins_wr_data_i(idat), .side_wr_en_i(se), .side_wr_dir_i(sdir),
    .side_wr_data_i(sdat), .in_data_o(ind), .flag_set_i(fs), .flag_clr_i(fc),
    .flag_idx_i(fi), .flag_wait_i(fw), .flag_wait_pol_i(fp), .stall_o(stall),
    .flags_o(flags), .fetch_addr_i(fa), .instr_o(ins), .gpio_in_i(pad),
    .gpio_level_o(lvl), .gpio_dir_o(dir), .irq_o(irq));
  smpa_pad_model pads (.level_i(lvl), .dir_i(dir), .ext_i(ext), .pad_o(pad));

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  task automatic results();
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic bus cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // writes a data word over a base/count range, wrapping, user pins only
  function automatic logic [31:0] put(logic [31:0] v, logic [4:0] b, logic [5:0] n,
                                      logic [31:0] d);
    logic [4:0] p;
    for (int i = 0; i < n; i++) begin
      p = b + 5'(i);
      if (p < 5'h1E) v[p] = d[i];
    end
    return v;
  endfunction : put

  // reference pins: later machine and side-set overwrite earlier writes
  always @(posedge clk_i) begin
    logic [31:0] l, dd, c;
    logic [4:0] b;
    logic [5:0] n;
    l = el;
    dd = ed;
    for (int s = 0; s < 4; s++) begin
      c = cfg[s];
      b = iset[s] ? c[15:11] : c[4:0];
      n = iset[s] ? {3'h0, c[18:16]} : c[10:5];
      if (ie[s] && idir[s]) dd = put(dd, b, n, idat[s]);
      if (ie[s] && !idir[s]) l = put(l, b, n, idat[s]);
      if (se[s] && sdir[s]) dd = put(dd, c[23:19], {3'h0, c[26:24]}, 32'(sdat[s]));
      if (se[s] && !sdir[s]) l = put(l, c[23:19], {3'h0, c[26:24]}, 32'(sdat[s]));
    end
    el <= rst_i ? 32'h0 : l;
    ed <= rst_i ? 32'h0 : dd;
  end

  // pin outputs compared each cycle away from the sampling edge
  always @(negedge clk_i) begin
    if (chk_on) begin
      chk(lvl, el);
      chk(dir, ed);
    end
  end

  // hang guard
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    logic [31:0] v;
    logic [15:0] w [4];
    for (int s = 0; s < 4; s++) cfg[s] = 32'h0;
    v = $urandom(17482);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(lvl | dir, 32'h0);
    chk({22'h0, irq, flags}, 32'h0);
    chk_on = 1'b1;
    // input view rotated to each machine's in base
    @(posedge clk_i);
    ext <= $urandom;
    for (int s = 0; s < 4; s++) begin
      cfg[s] = {5'($urandom), 27'h0};
      wb(1'b1, 8'(4 * s), cfg[s]);
    end
    repeat (4) @(negedge clk_i);
    for (int s = 0; s < 4; s++) chk(ind[s], 32'({ext, ext} >> cfg[s][31:27]));
    wb(1'b0, SMPA_OFF_GPIO_IN, 32'h0);
    chk(rd, ext);
    // random overlapping ranges, first pass all based at pin 28
    for (int k = 0; k < 5; k++) begin
      for (int s = 0; s < 4; s++) begin
        v = $urandom;
        v[10:5] = 6'(v[10:5] % 33);
        v[26:24] = 3'(v[26:24] % 6);
        if (k == 0) v[23:0] = {5'h1C, v[18:16], 5'h1C, v[10:5], 5'h1C};
        wb(1'b1, 8'(4 * s), v);
        cfg[s] = v;
      end
      repeat (200) begin
        @(posedge clk_i);
        ie <= 4'($urandom & $urandom);
        se <= 4'($urandom & $urandom);
        idir <= 4'($urandom);
        iset <= 4'($urandom);
        sdir <= 4'($urandom);
        for (int s = 0; s < 4; s++) idat[s] <= $urandom;
        for (int s = 0; s < 4; s++) sdat[s] <= 5'($urandom);
      end
      @(posedge clk_i);
      ie <= 4'h0;
      se <= 4'h0;
      wb(1'b0, SMPA_OFF_GPIO_LVL, 32'h0);
      chk(rd, el);
    end
    // shared flags from the bus and the interrupt masks
    wb(1'b1, SMPA_OFF_FLAG_SET, 32'hA5);
    wb(1'b0, SMPA_OFF_FLAG, 32'h0);
    chk(rd, 32'hA5);
    wb(1'b1, SMPA_OFF_IRQ0_MASK, 32'h2);
    wb(1'b1, SMPA_OFF_IRQ1_MASK, 32'h4);
    repeat (2) @(negedge clk_i);
    chk(32'(irq), 32'h2);
    wb(1'b1, SMPA_OFF_FLAG, 32'h0F);
    wb(1'b1, SMPA_OFF_IRQ0_MASK, 32'hFF);
    repeat (2) @(negedge clk_i);
    chk(32'(irq), 32'h0);
    // machine flag ops: clear 7, set 0, set and clear 6 together
    @(posedge clk_i);
    fs <= 4'h9;
    fc <= 4'h6;
    fi <= {3'h0, 3'h6, 3'h7, 3'h6};
    @(posedge clk_i);
    fs <= 4'h0;
    fc <= 4'h0;
    fw <= 4'hA;
    fp <= 4'hA;
    fi[1] <= 3'h4;
    fi[3] <= 3'h4;
    repeat (2) @(negedge clk_i);
    chk({22'h0, irq, flags}, 32'h161);
    chk(32'(stall), 32'hA);
    @(posedge clk_i);
    fs <= 4'h1;
    fi[0] <= 3'h4;
    @(posedge clk_i);
    fs <= 4'h0;
    repeat (2) @(negedge clk_i);
    chk({24'h0, stall, flags[7:4]}, 32'h7);
    @(posedge clk_i);
    fw <= 4'h0;
    // four fetch ports read one memory in the same cycle
    for (int s = 0; s < 4; s++) begin
      w[s] = 16'($urandom);
      wb(1'b1, 8'(SMPA_OFF_IMEM + 4 * s), {16'h0, w[s]});
    end
    @(posedge clk_i);
    for (int s = 0; s < 4; s++) fa[s] <= 5'(3 - s);
    repeat (2) @(negedge clk_i);
    for (int s = 0; s < 4; s++) chk(32'(ins[s]), 32'(w[3 - s]));
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    results();
  end
endmodule : smpa_top_tb
`default_nettype wire
